// file: dv/cmap_far_model.sv
// far-side model: framers, hdlc controller and link payload bus
module cmap_far_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire cmap_pkg::cmap_pay_t pay_i,
  output logic [7:0] loc_rx_o,
  output logic [7:0] pay_rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  logic live;
  logic [9:0] nxt;
  initial seen = 1'b0;
  always @(posedge sys_clk_i) seen <= reset_n_i & (seen | pay_i.strobe);
  // slot held between strobes, so the next slot is one on after the first strobe and 0 before it
  assign live = seen | pay_i.strobe;
  assign nxt = (!live || pay_i.slot == 10'h2FF) ? 10'h000 : pay_i.slot + 10'h001;
  initial begin
    loc_rx_o = 8'h00;
    pay_rx_o = 8'h00;
  end
  always @(negedge sys_clk_i) begin
    loc_rx_o <= nxt[7:0] ^ 8'h5A;
    // link payload bytes, forwarded messages included
    pay_rx_o <= nxt[7:0] ^ 8'hC3;
  end
endmodule

// file: dv/cmap_mapper_props.sv
// concurrent checks on the mapper ports
module cmap_mapper_props #(
  parameter int SLOT_DIV = 6
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic loc_strobe_o,
  input wire logic [9:0] loc_chan_o,
  input wire logic loc_frame_sync_o,
  input wire logic hdlc_chan_en_o,
  input wire logic [7:0] loc_tx_data_o,
  input wire cmap_pkg::cmap_pay_t pay_tx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = SLOT_DIV - 1;
  logic [9:0] prev_ff;
  logic seen_ff;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      seen_ff <= 1'b0;
      prev_ff <= 10'h000;
    end else if (pay_tx_o.strobe) begin
      seen_ff <= 1'b1;
      prev_ff <= pay_tx_o.slot;
    end
  end
  strobe_gap_a: assert property (pay_tx_o.strobe |=> !pay_tx_o.strobe ##GAP pay_tx_o.strobe)
    else $error("slot strobe spacing wrong");
  slot_step_a: assert property (pay_tx_o.strobe && seen_ff |->
    pay_tx_o.slot == ((prev_ff == 10'h2FF) ? 10'h000 : prev_ff + 10'h001))
    else $error("slot sequence broken");
  first_slot_a: assert property (pay_tx_o.strobe && !seen_ff |-> pay_tx_o.slot == 10'h000)
    else $error("first slot not zero");
  link_sync_a: assert property (pay_tx_o.sync || pay_tx_o.strobe |->
    pay_tx_o.strobe && (pay_tx_o.sync == (pay_tx_o.slot == 10'h000)))
    else $error("link sync misplaced");
  loc_pair_a: assert property (pay_tx_o.strobe |->
    loc_strobe_o == (pay_tx_o.slot < 10'h2C0) && loc_chan_o == pay_tx_o.slot)
    else $error("local strobe mismatch");
  loc_sync_a: assert property (loc_frame_sync_o |-> loc_strobe_o && loc_chan_o == 10'h000)
    else $error("local sync misplaced");
  hdlc_win_a: assert property (pay_tx_o.strobe |->
    hdlc_chan_en_o == (pay_tx_o.slot >= 10'h2A0 && pay_tx_o.slot < 10'h2C0))
    else $error("hdlc window wrong");
  idle_code_a: assert property (pay_tx_o.strobe && pay_tx_o.slot >= 10'h2C0 |->
    loc_tx_data_o == 8'hFF)
    else $error("spare slot not idle");
  slot_hold_a: assert property (!pay_tx_o.strobe |-> $stable(pay_tx_o.slot) &&
    $stable(loc_tx_data_o))
    else $error("slot outputs moved");
  reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i |=>
    !loc_strobe_o && !pay_tx_o.strobe && loc_tx_data_o == 8'hFF)
    else $error("outputs active in reset");
endmodule

bind cmap_mapper cmap_mapper_props #(.SLOT_DIV(SLOT_DIV)) i_props (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .loc_strobe_o(loc_strobe_o), .loc_chan_o(loc_chan_o),
  .loc_frame_sync_o(loc_frame_sync_o), .hdlc_chan_en_o(hdlc_chan_en_o),
  .loc_tx_data_o(loc_tx_data_o), .pay_tx_o(pay_tx_o));

// file: dv/testbench.sv
// self-checking bench for the channel mapper
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic loopback_i = 1'b0;
  logic tbl_wr_i = 1'b0;
  logic [9:0] tbl_addr_i = 10'h000;
  cmap_pkg::cmap_entry_t tbl_data_i = '0;
  logic [7:0] loc_rx, pay_rx, loc_tx;
  logic loc_strobe, loc_sync, sig_frame, hdlc_en;
  logic [9:0] loc_chan;
  cmap_pkg::cmap_pay_t pay_tx;
  int miscompares = 0;
  int checked = 0;
  int frames = 0;
  cmap_mapper #(.SLOT_DIV(2)) i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .loopback_i(loopback_i), .tbl_wr_i(tbl_wr_i), .tbl_addr_i(tbl_addr_i),
    .tbl_data_i(tbl_data_i), .loc_rx_data_i(loc_rx), .pay_rx_data_i(pay_rx),
    .loc_strobe_o(loc_strobe), .loc_chan_o(loc_chan), .loc_frame_sync_o(loc_sync),
    .loc_sig_frame_o(sig_frame), .hdlc_chan_en_o(hdlc_en), .loc_tx_data_o(loc_tx),
    .pay_tx_o(pay_tx));
  cmap_far_model i_far (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pay_i(pay_tx),
    .loc_rx_o(loc_rx), .pay_rx_o(pay_rx));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (pay_tx.sync === 1'b1) frames <= frames + 1;
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // slot 0 is avoided: the frame count steps at its end
  task automatic at(input int f, input int s);
    int n;
    n = 0;
    while (!(pay_tx.strobe === 1'b1 && pay_tx.slot === s[9:0] && frames == f + 1)) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 20000) begin
        miscompares++;
        close_out();
      end
    end
  endtask
  task automatic put(input int a, input cmap_pkg::cmap_kind_t k, input int i);
    tbl_wr_i = 1'b1;
    tbl_addr_i = a[9:0];
    tbl_data_i = '{kind: k, idx: i[9:0]};
    @(negedge sys_clk_i);
  endtask
  task automatic t_reset;
    chk({loc_strobe, pay_tx.strobe, loc_tx}, 10'h0FF);
    $display("test reset done");
  endtask
  task automatic t_map;
    for (int a = 0; a < 768; a++) put(a, cmap_pkg::CMAP_IDLE, 0);
    put(11, cmap_pkg::CMAP_VOICE, 3);
    put(30, cmap_pkg::CMAP_SIG, 3);
    put(40, cmap_pkg::CMAP_VOICE, 700);
    put(50, cmap_pkg::CMAP_HDLC, 690);
    put(60, cmap_pkg::CMAP_HDLC, 5);
    put(767, cmap_pkg::CMAP_VOICE, 671);
    put(768, cmap_pkg::CMAP_VOICE, 5);
    tbl_wr_i = 1'b0;
    // table lands during frame 0, so link-to-local bytes are all valid by frame 2
    at(1, 11);
    chk(pay_tx.data, 8'h59);
    at(1, 40);
    chk(pay_tx.data, 8'hFF);
    at(1, 50);
    chk(pay_tx.data, 8'hE8);
    at(1, 60);
    chk(pay_tx.data, 8'hFF);
    at(1, 512);
    chk(pay_tx.data, 8'hFF);
    at(1, 680);
    chk({hdlc_en, loc_strobe}, 2'h3);
    at(1, 720);
    chk({loc_strobe, loc_tx}, 9'h0FF);
    at(1, 767);
    chk(pay_tx.data, 8'hC5);
    at(2, 3);
    chk({sig_frame, loc_strobe, loc_chan, loc_tx}, {2'h1, 10'h003, 8'hC8});
    at(2, 671);
    chk(loc_tx, 8'h3C);
    at(2, 690);
    chk({hdlc_en, loc_tx}, 9'h1F1);
    $display("test map done");
  endtask
  task automatic t_sig;
    at(5, 3);
    chk({sig_frame, loc_tx}, 9'h1C9);
    at(11, 3);
    chk({sig_frame, loc_tx}, 9'h1C8);
    at(11, 30);
    chk(pay_tx.data, 8'h03);
    $display("test signalling done");
  endtask
  task automatic t_loop;
    loopback_i = 1'b1;
    at(3, 3);
    chk(loc_tx, 8'h59);
    loopback_i = 1'b0;
    at(4, 3);
    chk(loc_tx, 8'hC8);
    $display("test loopback done");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk_i);
    t_reset();
    reset_n_i = 1'b1;
    t_map();
    t_loop();
    t_sig();
    close_out();
  end
endmodule

// file: logic/cmap_counter.sv
// wrapping counter advanced by an enable, with a wrap pulse
module cmap_counter #(
  parameter int MAX = 768,
  parameter int W = 10
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  output logic [W-1:0] cnt_o,
  output logic wrap_o
);
  localparam logic [W-1:0] TOP = W'(MAX - 1);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // refused at elaboration: a count that cannot reach its top never wraps
  if (MAX < 2 || MAX > (1 << W)) begin
    $error("cmap_counter: MAX does not fit W");
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (en_i) begin
      nxt_cnt = (cnt_ff == TOP) ? '0 : cnt_ff + W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt_o = cnt_ff;
  assign wrap_o = en_i && (cnt_ff == TOP);
endmodule

// file: logic/cmap_mapper.sv
// transmit and receive channel mappers between span/hdlc side and link payload bus
// Functional notes
// - map 672 voice plus 32 hdlc into 768
// - separate transmit and receive mapping paths
// - carry robbed-bit signalling on voice channels
// - generate channel clock and sync for framers
// - signalling bits travel in dedicated link channels
// - loopback returns every received channel to source
// - up to 32 hdlc channels terminated
// - hdlc messages pass via shared ram and hdlc link channels
// - returned hdlc group deframed into shared ram
// - controller flags waiting message to processor
// - hdlc channel allocation changeable while running
// - twenty-eight spans fill the voice channel budget
// - framer exchanges data with both mappers
// - payload on parallel tdm bus to link
module cmap_mapper #(
  parameter int SLOT_DIV = cmap_pkg::SLOT_DIV
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic loopback_i,
  input wire logic tbl_wr_i,
  input wire logic [cmap_pkg::CHAN_W-1:0] tbl_addr_i,
  input wire cmap_pkg::cmap_entry_t tbl_data_i,
  input wire logic [cmap_pkg::DATA_W-1:0] loc_rx_data_i,
  input wire logic [cmap_pkg::DATA_W-1:0] pay_rx_data_i,
  output logic loc_strobe_o,
  output logic [cmap_pkg::CHAN_W-1:0] loc_chan_o,
  output logic loc_frame_sync_o,
  output logic loc_sig_frame_o,
  output logic hdlc_chan_en_o,
  output logic [cmap_pkg::DATA_W-1:0] loc_tx_data_o,
  output cmap_pkg::cmap_pay_t pay_tx_o
);
  localparam int LC = cmap_pkg::LINK_CHANS;
  localparam int NL = cmap_pkg::LOC_CHANS;
  localparam int NV = cmap_pkg::VOICE_CHANS;
  localparam int DIV_W = (SLOT_DIV > 1) ? $clog2(SLOT_DIV) : 1;

  // strobes need an idle cycle between slots, so a divider of 1 is refused
  if (SLOT_DIV < 2) begin
    $error("cmap_mapper: SLOT_DIV must be at least 2");
  end
  // span count fixes the voice channel budget
  if (cmap_pkg::SPANS * cmap_pkg::CH_PER_SPAN != NV) begin
    $error("cmap_mapper: span budget mismatch");
  end

  // timebase: divider pulse, link slot counter, superframe counter
  logic slot_en;
  logic [DIV_W-1:0] div_cnt;
  logic [cmap_pkg::CHAN_W-1:0] slot;
  logic frame_wrap;
  logic [cmap_pkg::FRAME_W-1:0] frame;

  cmap_counter #(.MAX(SLOT_DIV), .W(DIV_W)) u_div (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .en_i(1'b1),
    .cnt_o(div_cnt),
    .wrap_o(slot_en)
  );

  // one link frame of 768 slots
  cmap_counter #(.MAX(LC), .W(cmap_pkg::CHAN_W)) u_slot (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .en_i(slot_en),
    .cnt_o(slot),
    .wrap_o(frame_wrap)
  );

  // superframe position locates the robbed-bit frames
  cmap_counter #(.MAX(cmap_pkg::SUPERFRAME), .W(cmap_pkg::FRAME_W)) u_frame (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .en_i(frame_wrap),
    .cnt_o(frame),
    .wrap_o()
  );

  // channel stores: received from framers/hdlc, and bound for them
  logic [cmap_pkg::DATA_W-1:0] rx_buf [NL];
  logic [cmap_pkg::DATA_W-1:0] tx_buf [NL];
  logic [1:0] sig_rx [NV];
  logic [1:0] sig_tx [NV];
  cmap_pkg::cmap_entry_t map_tbl [LC];

  logic loopback_ff;
  logic loc_strobe_ff;
  logic [cmap_pkg::CHAN_W-1:0] loc_chan_ff;
  logic loc_frame_sync_ff;
  logic loc_sig_frame_ff;
  logic hdlc_chan_en_ff;
  logic [cmap_pkg::DATA_W-1:0] loc_tx_data_ff;
  cmap_pkg::cmap_pay_t pay_tx_ff;

  logic nxt_loopback;
  logic nxt_loc_strobe;
  logic [cmap_pkg::CHAN_W-1:0] nxt_loc_chan;
  logic nxt_loc_frame_sync;
  logic nxt_loc_sig_frame;
  logic nxt_hdlc_chan_en;
  logic [cmap_pkg::DATA_W-1:0] nxt_loc_tx_data;
  cmap_pkg::cmap_pay_t nxt_pay_tx;

  // store write controls
  logic loc_active;
  logic voice_slot;
  logic sig_frame;
  logic entry_ok;
  logic rx_buf_we;
  logic sig_rx_we;
  logic tx_buf_we;
  logic sig_tx_we;
  cmap_pkg::cmap_entry_t entry;
  logic [cmap_pkg::DATA_W-1:0] from_store;

  always_comb begin
    loc_active = (slot <= cmap_pkg::LAST_LOC);
    voice_slot = (slot <= cmap_pkg::LAST_VOICE);
    sig_frame = (frame == cmap_pkg::SIG_A_FRAME) || (frame == cmap_pkg::SIG_B_FRAME);
    entry = map_tbl[slot];
    entry_ok = 1'b0;
    unique case (entry.kind)
      cmap_pkg::CMAP_VOICE: entry_ok = (entry.idx <= cmap_pkg::LAST_VOICE);
      cmap_pkg::CMAP_SIG: entry_ok = (entry.idx <= cmap_pkg::LAST_VOICE);
      cmap_pkg::CMAP_HDLC: entry_ok = (entry.idx > cmap_pkg::LAST_VOICE) &&
                                      (entry.idx <= cmap_pkg::LAST_LOC);
      cmap_pkg::CMAP_IDLE: entry_ok = 1'b0;
    endcase
    rx_buf_we = slot_en && loc_active;
    sig_rx_we = slot_en && voice_slot && sig_frame;
    tx_buf_we = slot_en && entry_ok && (entry.kind != cmap_pkg::CMAP_SIG);
    sig_tx_we = slot_en && entry_ok && (entry.kind == cmap_pkg::CMAP_SIG);
  end

  // loopback control is registered and clears on reset
  always_comb begin
    nxt_loopback = loopback_i;
  end

  // local side: channel clock, sync and transmit data for framers and hdlc
  always_comb begin
    nxt_loc_strobe = slot_en && loc_active;
    nxt_loc_chan = loc_chan_ff;
    nxt_loc_frame_sync = 1'b0;
    nxt_loc_sig_frame = loc_sig_frame_ff;
    nxt_hdlc_chan_en = hdlc_chan_en_ff;
    nxt_loc_tx_data = loc_tx_data_ff;
    if (slot_en) begin
      // per-channel strobe, frame sync and signalling frame mark
      nxt_loc_chan = slot;
      nxt_loc_frame_sync = (slot == '0);
      nxt_loc_sig_frame = sig_frame;
      // hdlc controller owns the top 32 local channels
      // message bytes reach the controller only here
      nxt_hdlc_chan_en = loc_active && !voice_slot;
      if (!loc_active) begin
        nxt_loc_tx_data = cmap_pkg::IDLE_CODE;
      end else if (loopback_ff) begin
        // hand each received channel straight back to its source
        nxt_loc_tx_data = loc_rx_data_i;
      end else begin
        // receive mapper output toward the framers
        nxt_loc_tx_data = tx_buf[slot];
        if (voice_slot && sig_frame) begin
          // rob the low bit for the a or b signalling bit
          nxt_loc_tx_data[0] = (frame == cmap_pkg::SIG_A_FRAME) ? sig_tx[slot][0]
                                                                 : sig_tx[slot][1];
        end
      end
    end
  end

  // link side: transmit mapper fills the payload slot from the table entry
  always_comb begin
    from_store = cmap_pkg::IDLE_CODE;
    if (entry_ok) begin
      unique case (entry.kind)
        // signalling bits ride in their own link channels
        cmap_pkg::CMAP_SIG: from_store = {6'h00, sig_rx[entry.idx]};
        cmap_pkg::CMAP_VOICE: from_store = rx_buf[entry.idx];
        cmap_pkg::CMAP_HDLC: from_store = rx_buf[entry.idx];
        cmap_pkg::CMAP_IDLE: from_store = cmap_pkg::IDLE_CODE;
      endcase
    end
    nxt_pay_tx = pay_tx_ff;
    nxt_pay_tx.strobe = slot_en;
    nxt_pay_tx.sync = 1'b0;
    if (slot_en) begin
      // one byte per link slot on the parallel payload bus
      nxt_pay_tx.sync = (slot == '0);
      nxt_pay_tx.slot = slot;
      nxt_pay_tx.data = from_store;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      loopback_ff <= 1'b0;
      loc_strobe_ff <= 1'b0;
      loc_chan_ff <= '0;
      loc_frame_sync_ff <= 1'b0;
      loc_sig_frame_ff <= 1'b0;
      hdlc_chan_en_ff <= 1'b0;
      loc_tx_data_ff <= cmap_pkg::IDLE_CODE;
      pay_tx_ff <= '{strobe: 1'b0, sync: 1'b0, slot: '0, data: cmap_pkg::IDLE_CODE};
    end else begin
      loopback_ff <= nxt_loopback;
      loc_strobe_ff <= nxt_loc_strobe;
      loc_chan_ff <= nxt_loc_chan;
      loc_frame_sync_ff <= nxt_loc_frame_sync;
      loc_sig_frame_ff <= nxt_loc_sig_frame;
      hdlc_chan_en_ff <= nxt_hdlc_chan_en;
      loc_tx_data_ff <= nxt_loc_tx_data;
      pay_tx_ff <= nxt_pay_tx;
    end
  end

  // stores hold no reset; the table must be loaded before traffic means anything
  always_ff @(posedge sys_clk_i) begin
    // one table entry per link channel, loadable any time
    // rewriting hdlc entries reallocates channels on the fly
    if (tbl_wr_i && (tbl_addr_i < cmap_pkg::CHAN_W'(LC))) begin
      map_tbl[tbl_addr_i] <= tbl_data_i;
    end
    // transmit mapper captures framer and hdlc bytes
    if (rx_buf_we) begin
      rx_buf[slot] <= loc_rx_data_i;
    end
    if (sig_rx_we) begin
      if (frame == cmap_pkg::SIG_A_FRAME) begin
        sig_rx[slot][0] <= loc_rx_data_i[0];
      end else begin
        sig_rx[slot][1] <= loc_rx_data_i[0];
      end
    end
    // returned hdlc group lands in the controller's channels
    // receive mapper scatters link bytes to local channels
    if (tx_buf_we) begin
      tx_buf[entry.idx] <= pay_rx_data_i;
    end
    if (sig_tx_we) begin
      sig_tx[entry.idx] <= pay_rx_data_i[1:0];
    end
  end

  assign loc_strobe_o = loc_strobe_ff;
  assign loc_chan_o = loc_chan_ff;
  assign loc_frame_sync_o = loc_frame_sync_ff;
  assign loc_sig_frame_o = loc_sig_frame_ff;
  assign hdlc_chan_en_o = hdlc_chan_en_ff;
  assign loc_tx_data_o = loc_tx_data_ff;
  assign pay_tx_o = pay_tx_ff;
endmodule

// file: logic/cmap_pkg.sv
// shared constants and carrier types for the span channel mapper
package cmap_pkg;
  localparam int LINK_CHANS = 768;
  localparam int VOICE_CHANS = 672;
  localparam int HDLC_CHANS = 32;
  localparam int SPANS = 28;
  localparam int CH_PER_SPAN = 24;
  localparam int LOC_CHANS = VOICE_CHANS + HDLC_CHANS;
  localparam int SUPERFRAME = 12;
  localparam int CHAN_W = 10;
  localparam int FRAME_W = 4;
  localparam int DATA_W = 8;
  localparam int SLOT_DIV = 6;
  localparam logic [CHAN_W-1:0] LAST_VOICE = 10'h29F;
  localparam logic [CHAN_W-1:0] LAST_LOC = 10'h2BF;
  localparam logic [FRAME_W-1:0] SIG_A_FRAME = 4'h5;
  localparam logic [FRAME_W-1:0] SIG_B_FRAME = 4'hB;
  localparam logic [DATA_W-1:0] IDLE_CODE = 8'hFF;

  typedef enum logic [1:0] {
    CMAP_IDLE = 2'h0,
    CMAP_VOICE = 2'h1,
    CMAP_HDLC = 2'h3,
    CMAP_SIG = 2'h2
  } cmap_kind_t;

  typedef struct packed {
    cmap_kind_t kind;
    logic [CHAN_W-1:0] idx;
  } cmap_entry_t;

  typedef struct packed {
    logic strobe;
    logic sync;
    logic [CHAN_W-1:0] slot;
    logic [DATA_W-1:0] data;
  } cmap_pay_t;
endpackage
